// >>> dmme_core.sv
/*
 * Execution core for byte, bit and pointer moves, code table reads,
 * external data transfers and unsigned multiply.
 * Assumes a code memory that returns the three bytes at CODE_ADDR_OUT in
 * the same cycle, and an external data RAM on the multiplexed port.
 */
`timescale 1ns/100ps
module dmme_core import dmme_pkg::*; (
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	input wire logic [23:0] CODE_DATA_IN,
	input wire logic [7:0] LAD_IN,
	output logic [15:0] CODE_ADDR_OUT,
	output logic [7:0] LAD_OUT,
	output logic LAD_OE_OUT,
	output logic ALE_OUT,
	output logic RD_N_OUT,
	output logic WR_N_OUT,
	output logic [7:0] HIGH_ADDR_OUT,
	output logic [7:0] ACC_OUT,
	output logic [7:0] B_OUT,
	output logic [7:0] PSW_OUT,
	output logic [15:0] DATA_POINTER_OUT,
	output logic RETIRE_OUT,
	output logic UNSUP_OUT
);

	// ****************************************************************
	// State
	// ****************************************************************
	logic [7:0] iram [0:255];
	logic [7:0] acc_r;
	logic [7:0] b_r;
	logic [7:0] psw_r;
	logic [7:0] p2_r;
	logic [15:0] data_pointer_r;
	logic [15:0] pc_r;
	logic [15:0] code_addr_r;
	dmme_state_e state_r;
	dmme_kind_e kind_r;
	logic [2:0] cnt_r;
	dmme_xop_s pend_r;
	dmme_xop_s cm;
	dmme_dec_s dec;
	logic done;
	logic retire_r;
	logic unsup_r;
	logic rd_pend_r;
	logic ale_r;
	logic lad_oe_r;
	logic rd_n_r;
	logic wr_n_r;
	logic [7:0] lad_r;
	logic [7:0] hi_r;
	logic [7:0] acc_cur;
	logic [7:0] b1;
	logic [7:0] b2;
	logic [7:0] b3;
	logic [7:0] ri_ptr;
	logic [7:0] rn_val;
	logic [7:0] bit_addr;
	logic [7:0] bit_src;
	logic [7:0] bit_mod;
	logic [15:0] prod;
	logic mul_start;

	assign b1 = CODE_DATA_IN[7:0];
	assign b2 = CODE_DATA_IN[15:8];
	assign b3 = CODE_DATA_IN[23:16];
	// Forward a read that lands this cycle so the next instruction sees it
	assign acc_cur = rd_pend_r ? LAD_IN : acc_r;

	// ****************************************************************
	// Address helpers
	// ****************************************************************
	function automatic logic [7:0] reg_addr(input logic [2:0] n);
		return {3'h0, psw_r[PSW_RS_HI:PSW_RS_LO], n};
	endfunction

	function automatic logic [7:0] bit_byte(input logic [7:0] ba);
		return ba[7] ? {ba[7:3], 3'h0} : BIT_AREA_BASE + {4'h0, ba[6:3]};
	endfunction

	// Unmapped special addresses read as zero and ignore writes
	function automatic logic [7:0] dir_rd(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (!a[7]) begin
			v = iram[{1'h0, a[6:0]}];
		end else begin
			case (a)
				SFR_ACC: v = acc_cur;
				SFR_B: v = b_r;
				SFR_PSW: v = psw_r;
				SFR_DPL: v = data_pointer_r[7:0];
				SFR_DPH: v = data_pointer_r[15:8];
				SFR_P2: v = p2_r;
				default: v = 8'h00;
			endcase
		end
		return v;
	endfunction

	// ****************************************************************
	// Decode
	// ****************************************************************
	always_comb begin
		ri_ptr = iram[reg_addr({2'h0, b1[0]})];
		rn_val = iram[reg_addr(b1[2:0])];
		bit_addr = bit_byte(b2);
		bit_src = dir_rd(bit_addr);
		bit_mod = bit_src;
		bit_mod[b2[2:0]] = psw_r[PSW_CY];
		dec = '0;
		dec.kind = K_PLAIN;
		dec.len = 2'h1;
		dec.ncyc = CYC_SHORT;
		unique casez (b1)
			OP_MOV_DIR_A: begin
				dec.len = 2'h2;
				dec.op.wd_en = 1'h1;
				dec.op.wd_addr = b2;
				dec.op.wd_data = acc_cur;
			end
			OP_MOV_DIR_RN: begin
				dec.len = 2'h2;
				dec.ncyc = CYC_LONG;
				dec.op.wd_en = 1'h1;
				dec.op.wd_addr = b2;
				dec.op.wd_data = rn_val;
			end
			OP_MOV_DIR_DIR: begin
				dec.len = 2'h3;
				dec.ncyc = CYC_LONG;
				dec.op.wd_en = 1'h1;
				dec.op.wd_addr = b3;
				dec.op.wd_data = dir_rd(b2);
			end
			OP_MOV_DIR_IND: begin
				dec.len = 2'h2;
				dec.ncyc = CYC_LONG;
				dec.op.wd_en = 1'h1;
				dec.op.wd_addr = b2;
				dec.op.wd_data = iram[ri_ptr];
			end
			OP_MOV_DIR_IMM: begin
				dec.len = 2'h3;
				dec.ncyc = CYC_LONG;
				dec.op.wd_en = 1'h1;
				dec.op.wd_addr = b2;
				dec.op.wd_data = b3;
			end
			OP_MOV_IND_A: begin
				dec.op.wi_en = 1'h1;
				dec.op.wi_addr = ri_ptr;
				dec.op.wi_data = acc_cur;
			end
			OP_MOV_IND_DIR: begin
				dec.len = 2'h2;
				dec.ncyc = CYC_LONG;
				dec.op.wi_en = 1'h1;
				dec.op.wi_addr = ri_ptr;
				dec.op.wi_data = dir_rd(b2);
			end
			OP_MOV_IND_IMM: begin
				dec.len = 2'h2;
				dec.op.wi_en = 1'h1;
				dec.op.wi_addr = ri_ptr;
				dec.op.wi_data = b2;
			end
			OP_MOV_C_BIT: begin
				dec.len = 2'h2;
				dec.op.cy_en = 1'h1;
				dec.op.cy = bit_src[b2[2:0]];
			end
			OP_MOV_BIT_C: begin
				dec.len = 2'h2;
				dec.ncyc = CYC_LONG;
				dec.op.wd_en = 1'h1;
				dec.op.wd_addr = bit_addr;
				dec.op.wd_data = bit_mod;
			end
			OP_MOV_DP_IMM: begin
				dec.len = 2'h3;
				dec.ncyc = CYC_LONG;
				dec.op.dp_en = 1'h1;
				dec.op.dp = {b2, b3};
			end
			OP_CODE_DP: begin
				dec.kind = K_CODE;
				dec.ncyc = CYC_LONG;
				dec.caddr = data_pointer_r + {8'h00, acc_cur};
			end
			OP_CODE_PC: begin
				dec.kind = K_CODE;
				dec.ncyc = CYC_LONG;
				dec.caddr = pc_r + 16'h0001 + {8'h00, acc_cur};
			end
			OP_XRD_DP, OP_XWR_DP: begin
				dec.kind = b1[4] ? K_XWR : K_XRD;
				dec.ncyc = CYC_LONG;
				dec.use_dp = 1'h1;
				dec.xa_lo = data_pointer_r[7:0];
				dec.xa_hi = data_pointer_r[15:8];
			end
			OP_XRD_RI, OP_XWR_RI: begin
				dec.kind = b1[4] ? K_XWR : K_XRD;
				dec.ncyc = CYC_LONG;
				dec.xa_lo = ri_ptr;
			end
			OP_MUL: begin
				dec.kind = K_MUL;
				dec.ncyc = CYC_MUL;
			end
			default: begin
				dec.kind = K_BAD;
			end
		endcase
	end

	// ****************************************************************
	// Commit selection
	// ****************************************************************
	assign mul_start = (state_r == ST_DECODE) && (dec.kind == K_MUL);

	dmme_mul u_mul (
		.clk_in(MCLK_IN),
		.rst_in(RST_IN),
		.ce_in(CE_IN),
		.start_in(mul_start),
		.a_in(acc_cur),
		.b_in(b_r),
		.prod_out(prod)
	);

	always_comb begin
		cm = '0;
		done = 1'h0;
		unique case (state_r)
			ST_DECODE: begin
				if (dec.ncyc == CYC_SHORT) begin
					cm = dec.op;
					done = 1'h1;
				end
			end
			ST_EXEC: begin
				cm = pend_r;
				done = 1'h1;
				if (kind_r == K_CODE) begin
					cm.acc_en = 1'h1;
					cm.acc = CODE_DATA_IN[7:0];
				end
			end
			ST_MUL: begin
				if (cnt_r == CYC_MUL) begin
					done = 1'h1;
					cm.acc_en = 1'h1;
					cm.acc = prod[7:0];
					cm.b_en = 1'h1;
					cm.b = prod[15:8];
					cm.ov_en = 1'h1;
					cm.ov = |prod[15:8];
					cm.cy_en = 1'h1;
					cm.cy = 1'h0;
				end
			end
		endcase
	end

	// ****************************************************************
	// Sequencer and program counter
	// ****************************************************************
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			state_r <= ST_DECODE;
			kind_r <= K_PLAIN;
			cnt_r <= 3'h0;
			pend_r <= '0;
			pc_r <= PC_RESET;
			code_addr_r <= PC_RESET;
			retire_r <= 1'h0;
			unsup_r <= 1'h0;
		end else if (CE_IN) begin
			retire_r <= done;
			unsup_r <= (state_r == ST_DECODE) && (dec.kind == K_BAD);
			unique case (state_r)
				ST_DECODE: begin
					kind_r <= dec.kind;
					pend_r <= dec.op;
					cnt_r <= CYC_LONG;
					pc_r <= pc_r + {14'h0000, dec.len};
					if (dec.ncyc == CYC_SHORT) begin
						code_addr_r <= pc_r + {14'h0000, dec.len};
					end else begin
						state_r <= (dec.kind == K_MUL) ? ST_MUL : ST_EXEC;
						if (dec.kind == K_CODE) begin
							code_addr_r <= dec.caddr;
						end
					end
				end
				ST_EXEC: begin
					state_r <= ST_DECODE;
					code_addr_r <= pc_r;
				end
				ST_MUL: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == CYC_MUL) begin
						state_r <= ST_DECODE;
						code_addr_r <= pc_r;
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Architectural registers
	// ****************************************************************
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			acc_r <= ACC_RESET;
			b_r <= B_RESET;
			psw_r <= PSW_RESET;
			data_pointer_r <= DATA_POINTER_RESET;
			p2_r <= P2_RESET;
		end else if (CE_IN) begin
			acc_r <= acc_cur;
			if (cm.wd_en) begin
				unique case (cm.wd_addr)
					SFR_ACC: acc_r <= cm.wd_data;
					SFR_B: b_r <= cm.wd_data;
					SFR_PSW: psw_r <= cm.wd_data;
					SFR_DPL: data_pointer_r[7:0] <= cm.wd_data;
					SFR_DPH: data_pointer_r[15:8] <= cm.wd_data;
					SFR_P2: p2_r <= cm.wd_data;
					default: ;
				endcase
			end
			if (cm.acc_en) begin
				acc_r <= cm.acc;
			end
			if (cm.b_en) begin
				b_r <= cm.b;
			end
			if (cm.cy_en) begin
				psw_r[PSW_CY] <= cm.cy;
			end
			if (cm.ov_en) begin
				psw_r[PSW_OV] <= cm.ov;
			end
			if (cm.dp_en) begin
				data_pointer_r <= cm.dp;
			end
		end
	end

	// No reset here so the array can map onto a plain RAM
	always_ff @(posedge MCLK_IN) begin
		if (!RST_IN && CE_IN) begin
			if (cm.wi_en) begin
				iram[cm.wi_addr] <= cm.wi_data;
			end
			if (cm.wd_en && !cm.wd_addr[7]) begin
				iram[{1'h0, cm.wd_addr[6:0]}] <= cm.wd_data;
			end
		end
	end

	// ****************************************************************
	// External data bus
	// ****************************************************************
	// Strobe phase overlaps the next instruction's decode cycle
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			ale_r <= 1'h0;
			lad_r <= 8'h00;
			lad_oe_r <= 1'h0;
			rd_n_r <= 1'h1;
			wr_n_r <= 1'h1;
			hi_r <= P2_RESET;
			rd_pend_r <= 1'h0;
		end else if (CE_IN) begin
			ale_r <= 1'h0;
			lad_oe_r <= 1'h0;
			rd_n_r <= 1'h1;
			wr_n_r <= 1'h1;
			hi_r <= p2_r;
			rd_pend_r <= (state_r == ST_EXEC) && (kind_r == K_XRD);
			if (state_r == ST_DECODE && (dec.kind == K_XRD || dec.kind == K_XWR)) begin
				ale_r <= 1'h1;
				lad_oe_r <= 1'h1;
				lad_r <= dec.xa_lo;
				hi_r <= dec.use_dp ? dec.xa_hi : p2_r;
			end else if (state_r == ST_EXEC && (kind_r == K_XRD || kind_r == K_XWR)) begin
				hi_r <= hi_r;
				if (kind_r == K_XWR) begin
					lad_r <= acc_cur;
					lad_oe_r <= 1'h1;
					wr_n_r <= 1'h0;
				end else begin
					rd_n_r <= 1'h0;
				end
			end
		end
	end

	assign CODE_ADDR_OUT = code_addr_r;
	assign LAD_OUT = lad_r;
	assign LAD_OE_OUT = lad_oe_r;
	assign ALE_OUT = ale_r;
	assign RD_N_OUT = rd_n_r;
	assign WR_N_OUT = wr_n_r;
	assign HIGH_ADDR_OUT = hi_r;
	assign ACC_OUT = acc_r;
	assign B_OUT = b_r;
	assign PSW_OUT = psw_r;
	assign DATA_POINTER_OUT = data_pointer_r;
	assign RETIRE_OUT = retire_r;
	assign UNSUP_OUT = unsup_r;

endmodule

// >>> dmme_pkg.sv
/*
 * Shared constants and types for the data-move and multiply execution block:
 * opcode patterns, special register addresses, field positions, reset values,
 * cycle counts, the decoded-operation carrier and the sequencer states.
 * Assumes every design file imports the whole package.
 */
// Overview of operation
// - F5 stores accumulator to direct byte, 1 cycle
// - 10001rrr copies working register to direct, 2 cycles
// - 85 copies direct source to direct destination
// - 1010011i stores direct byte through pointer register
// - Bit moves use carry, touch nothing else
// - A2 loads carry from bit, 1 cycle
// - 92 writes carry into bit, 2 cycles
// - 90 loads data pointer, high byte first
// - Table read address is accumulator plus base
// - Program counter base advanced first, 2 cycles
// - Data pointer base left unchanged, 2 cycles
// - Pointer register gives 8-bit external address
// - Data pointer high byte on high port
// - High port latch kept during external transfer
// - External transfers both directions, 2 cycles each
// - Multiply: low to accumulator, high to B, overflow
// - Multiply clears carry, takes 4 cycles
package dmme_pkg;

	// ****************************************************************
	// Opcode patterns
	// ****************************************************************
	localparam logic [7:0] OP_MOV_DIR_A = 8'hf5;
	localparam logic [7:0] OP_MOV_DIR_RN = 8'b1000_1???;
	localparam logic [7:0] OP_MOV_DIR_DIR = 8'h85;
	localparam logic [7:0] OP_MOV_DIR_IND = 8'b1000_011?;
	localparam logic [7:0] OP_MOV_DIR_IMM = 8'h75;
	localparam logic [7:0] OP_MOV_IND_A = 8'b1111_011?;
	localparam logic [7:0] OP_MOV_IND_DIR = 8'b1010_011?;
	localparam logic [7:0] OP_MOV_IND_IMM = 8'b0111_011?;
	localparam logic [7:0] OP_MOV_C_BIT = 8'ha2;
	localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
	localparam logic [7:0] OP_MOV_DP_IMM = 8'h90;
	localparam logic [7:0] OP_CODE_DP = 8'h93;
	localparam logic [7:0] OP_CODE_PC = 8'h83;
	localparam logic [7:0] OP_XRD_DP = 8'he0;
	localparam logic [7:0] OP_XRD_RI = 8'b1110_001?;
	localparam logic [7:0] OP_XWR_DP = 8'hf0;
	localparam logic [7:0] OP_XWR_RI = 8'b1111_001?;
	localparam logic [7:0] OP_MUL = 8'ha4;

	// ****************************************************************
	// Special register addresses and fields
	// ****************************************************************
	localparam logic [7:0] SFR_ACC = 8'he0;
	localparam logic [7:0] SFR_B = 8'hf0;
	localparam logic [7:0] SFR_PSW = 8'hd0;
	localparam logic [7:0] SFR_DPL = 8'h82;
	localparam logic [7:0] SFR_DPH = 8'h83;
	localparam logic [7:0] SFR_P2 = 8'ha0;
	localparam logic [7:0] BIT_AREA_BASE = 8'h20;
	localparam int PSW_CY = 7;
	localparam int PSW_RS_HI = 4;
	localparam int PSW_RS_LO = 3;
	localparam int PSW_OV = 2;

	// ****************************************************************
	// Reset values and cycle counts
	// ****************************************************************
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] B_RESET = 8'h00;
	localparam logic [7:0] PSW_RESET = 8'h00;
	localparam logic [15:0] DATA_POINTER_RESET = 16'h0000;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] P2_RESET = 8'hff;
	localparam logic [2:0] CYC_SHORT = 3'h1;
	localparam logic [2:0] CYC_LONG = 3'h2;
	localparam logic [2:0] CYC_MUL = 3'h4;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {K_PLAIN, K_CODE, K_XRD, K_XWR, K_MUL, K_BAD} dmme_kind_e;
	typedef enum logic [1:0] {ST_DECODE, ST_EXEC, ST_MUL} dmme_state_e;

	typedef struct packed {
		logic wd_en;
		logic [7:0] wd_addr;
		logic [7:0] wd_data;
		logic wi_en;
		logic [7:0] wi_addr;
		logic [7:0] wi_data;
		logic acc_en;
		logic [7:0] acc;
		logic b_en;
		logic [7:0] b;
		logic cy_en;
		logic cy;
		logic ov_en;
		logic ov;
		logic dp_en;
		logic [15:0] dp;
	} dmme_xop_s;

	typedef struct packed {
		dmme_xop_s op;
		dmme_kind_e kind;
		logic [1:0] len;
		logic [2:0] ncyc;
		logic [15:0] caddr;
		logic [7:0] xa_lo;
		logic [7:0] xa_hi;
		logic use_dp;
	} dmme_dec_s;

endpackage

// >>> dmme_mul.sv
/*
 * Sequential 8x8 unsigned multiplier, two multiplier bits per clock.
 * Assumes the caller pulses start with stable operands and reads the
 * product combinationally three enabled clocks later.
 */
`timescale 1ns/100ps
module dmme_mul import dmme_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic start_in,
	input wire logic [7:0] a_in,
	input wire logic [7:0] b_in,
	output logic [15:0] prod_out
);

	logic [15:0] mcand_r;
	logic [15:0] part_r;
	logic [5:0] mplier_r;

	function automatic logic [15:0] pp(input logic [15:0] m, input logic [1:0] d);
		return (d[0] ? m : 16'h0000) + (d[1] ? {m[14:0], 1'h0} : 16'h0000);
	endfunction

	// Last step stays combinational so four cycles cover all eight bits
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mcand_r <= 16'h0000;
			part_r <= 16'h0000;
			mplier_r <= 6'h00;
		end else if (ce_in) begin
			if (start_in) begin
				part_r <= pp({8'h00, a_in}, b_in[1:0]);
				mcand_r <= {6'h00, a_in, 2'h0};
				mplier_r <= b_in[7:2];
			end else begin
				part_r <= part_r + pp(mcand_r, mplier_r[1:0]);
				mcand_r <= {mcand_r[13:0], 2'h0};
				mplier_r <= {2'h0, mplier_r[5:2]};
			end
		end
	end

	assign prod_out = part_r + pp(mcand_r, mplier_r[1:0]);

endmodule

// >>> dmme_core_chk.sv
/*
 * Port checker for dmme_core: bus phases, moves and multiply.
 * Assumes CE_IN stays high while a checked instruction runs.
 */
`timescale 1ns/100ps
module dmme_core_chk import dmme_pkg::*; (
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	input wire logic [23:0] CODE_DATA_IN,
	input wire logic [7:0] LAD_IN,
	input wire logic [15:0] CODE_ADDR_OUT,
	input wire logic [7:0] LAD_OUT,
	input wire logic LAD_OE_OUT,
	input wire logic ALE_OUT,
	input wire logic RD_N_OUT,
	input wire logic WR_N_OUT,
	input wire logic [7:0] HIGH_ADDR_OUT,
	input wire logic [7:0] ACC_OUT,
	input wire logic [7:0] B_OUT,
	input wire logic [7:0] PSW_OUT,
	input wire logic [15:0] DATA_POINTER_OUT,
	input wire logic RETIRE_OUT,
	input wire logic UNSUP_OUT
);
	// ********
	// Sequences
	// ********
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (RST_IN);
	// Decode cycle: first after reset, else right after a retire
	sequence s_dec(logic [7:0] op);
		CE_IN && ($past(RST_IN) || RETIRE_OUT || UNSUP_OUT) && CODE_DATA_IN[7:0] == op;
	endsequence
	sequence s_xfer;
		ALE_OUT && LAD_OE_OUT ##1 !ALE_OUT && (RD_N_OUT != WR_N_OUT);
	endsequence
	sequence s_idle;
		!ALE_OUT && RD_N_OUT && WR_N_OUT;
	endsequence
	// ********
	// Assertions
	// ********
	AST_ALE_STROBE: assert property (CE_IN && ALE_OUT |-> s_xfer)
		else $error("strobe missing after address phase");
	AST_WR_DATA: assert property (!WR_N_OUT |-> LAD_OE_OUT && LAD_OUT == ACC_OUT)
		else $error("write phase without accumulator data");
	AST_RD_FLOAT: assert property (!RD_N_OUT |-> !LAD_OE_OUT && $past(ALE_OUT))
		else $error("read phase with bus driven");
	AST_HIGH_KEEP: assert property (s_idle ##1 s_xfer ##1 s_idle |->
		HIGH_ADDR_OUT == $past(HIGH_ADDR_OUT, 3))
		else $error("high port latch lost");
	AST_DP_XFER: assert property (s_dec(OP_XRD_DP) or s_dec(OP_XWR_DP) |=> ALE_OUT &&
		HIGH_ADDR_OUT == DATA_POINTER_OUT[15:8] && LAD_OUT == DATA_POINTER_OUT[7:0])
		else $error("pointer address wrong");
	AST_DP_LOAD: assert property (s_dec(OP_MOV_DP_IMM) |-> ##2 DATA_POINTER_OUT ==
		{$past(CODE_DATA_IN[15:8], 2), $past(CODE_DATA_IN[23:16], 2)})
		else $error("pointer load wrong");
	AST_ACC_STORE: assert property (s_dec(OP_MOV_DIR_A) ##0 CODE_DATA_IN[15:8] == SFR_B
		|=> B_OUT == ACC_OUT && RETIRE_OUT)
		else $error("accumulator store wrong");
	AST_CY_LOAD: assert property (s_dec(OP_MOV_C_BIT) ##0 CODE_DATA_IN[15:8] == 8'he7
		|=> PSW_OUT[PSW_CY] == ACC_OUT[7] && RETIRE_OUT)
		else $error("carry load wrong");
	AST_TABLE: assert property (s_dec(OP_CODE_DP) |=> CODE_ADDR_OUT == DATA_POINTER_OUT +
		{8'h00, ACC_OUT} ##1 DATA_POINTER_OUT == $past(DATA_POINTER_OUT, 2))
		else $error("table address wrong");
	AST_TABLE_PC: assert property (s_dec(OP_CODE_PC) |=> CODE_ADDR_OUT ==
		$past(CODE_ADDR_OUT) + 16'h0001 + {8'h00, ACC_OUT})
		else $error("counter based table address wrong");
	AST_MUL: assert property (s_dec(OP_MUL) |-> ##4 {B_OUT, ACC_OUT} == $past(ACC_OUT, 4) *
		$past(B_OUT, 4) && !PSW_OUT[PSW_CY] && PSW_OUT[PSW_OV] == (B_OUT != 8'h00))
		else $error("product or flags wrong");
	AST_MUL_TIME: assert property (s_dec(OP_MUL) |=> !RETIRE_OUT [*3] ##1 RETIRE_OUT)
		else $error("multiply length wrong");
	AST_UNSUP: assert property (s_dec(8'h00) |=> UNSUP_OUT && RETIRE_OUT)
		else $error("unsupported opcode not flagged");
endmodule

bind dmme_core dmme_core_chk dmme_core_chk_inst (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN),
	.CE_IN(CE_IN), .CODE_DATA_IN(CODE_DATA_IN), .LAD_IN(LAD_IN),
	.CODE_ADDR_OUT(CODE_ADDR_OUT), .LAD_OUT(LAD_OUT), .LAD_OE_OUT(LAD_OE_OUT),
	.ALE_OUT(ALE_OUT), .RD_N_OUT(RD_N_OUT), .WR_N_OUT(WR_N_OUT),
	.HIGH_ADDR_OUT(HIGH_ADDR_OUT), .ACC_OUT(ACC_OUT), .B_OUT(B_OUT), .PSW_OUT(PSW_OUT),
	.DATA_POINTER_OUT(DATA_POINTER_OUT), .RETIRE_OUT(RETIRE_OUT), .UNSUP_OUT(UNSUP_OUT));

// >>> dmme_ext_ram.sv
/*
 * External data RAM on the multiplexed port, 64K bytes.
 * Assumes the bench resolves the shared low bus and preloads mem.
 */
`timescale 1ns/100ps
module dmme_ext_ram (
	input wire logic clk_in,
	input wire logic ale_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic oe_in,
	input wire logic [7:0] lad_in,
	input wire logic [7:0] high_in,
	output logic [7:0] lad_out
);
	// ********
	// Storage
	// ********
	logic [7:0] mem [65536];
	logic [15:0] addr_r;
	logic [7:0] last_r = 8'h00;
	always @(posedge clk_in) begin
		if (ale_in)
			addr_r <= {high_in, lad_in};
		if (!wr_n_in && oe_in)
			mem[addr_r] <= lad_in;
		last_r <= lad_out;
	end
	// Released bus toggles so a stale byte never looks valid
	assign lad_out = !rd_n_in ? mem[addr_r] : ~last_r;
endmodule

// >>> data_move_multiply_exec_tb_top.sv
/*
 * Bench for dmme_core: a fixed program of moves, transfers, multiply with random operands.
 * Assumes the checker binds itself and the RAM model holds xdata.
 */
`timescale 1ns/100ps
module data_move_multiply_exec_tb_top;
	import dmme_pkg::*;
	// ********
	// Wiring
	// ********
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] rom [65536];
	logic [7:0] prog [30];
	logic [15:0] ca, data_pointer;
	logic [7:0] lad_o, hi_a, acc, b, psw, ram_q, lad_bus;
	logic oe, ale, rd_n, wr_n, retire, unsup;
	int err_count = 0;
	int num_checks = 0;
	int seed = 32'h5d28f96e;
	always #10 clk = ~clk;
	assign lad_bus = oe ? lad_o : ram_q;
	dmme_core dmme_core_inst (.MCLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
		.CODE_DATA_IN({rom[ca + 16'h0002], rom[ca + 16'h0001], rom[ca]}),
		.LAD_IN(lad_bus), .CODE_ADDR_OUT(ca), .LAD_OUT(lad_o), .LAD_OE_OUT(oe),
		.ALE_OUT(ale), .RD_N_OUT(rd_n), .WR_N_OUT(wr_n), .HIGH_ADDR_OUT(hi_a),
		.ACC_OUT(acc), .B_OUT(b), .PSW_OUT(psw), .DATA_POINTER_OUT(data_pointer),
		.RETIRE_OUT(retire), .UNSUP_OUT(unsup));
	dmme_ext_ram dmme_ext_ram_inst (.clk_in(clk), .ale_in(ale), .rd_n_in(rd_n),
		.wr_n_in(wr_n), .oe_in(oe), .lad_in(lad_bus), .high_in(hi_a), .lad_out(ram_q));
	// ********
	// Checks
	// ********
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic finish_test;
		if (err_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Final acc, b, dph, dpl and carry/overflow mask
	function automatic logic [39:0] expect_state(input logic [7:0] x, y, r, z,
		input logic [15:0] base);
		logic [15:0] p;
		logic [7:0] t, bb;
		p = {8'h00, x} * {8'h00, y};
		t = rom[base + {8'h00, p[7:0]}];
		bb = {p[15:9], t[7]};
		return {z, z, r, bb, t[7], 4'h0, p[15:8] != 8'h00, 2'h0};
	endfunction
	// ********
	// Sequence
	// ********
	initial begin
		logic [7:0] x, y, r, z, dh, dl, op;
		logic [15:0] base;
		int n, k, it;
		for (n = 0; n < 65536; n++)
			rom[n] = n[7:0] ^ n[15:8] ^ 8'h3c;
		for (it = 0; it < 24; it++) begin
			x = 8'($random(seed));
			y = 8'($random(seed));
			// Pointer kept off R0 itself so the indirect store cannot move it
			r = 8'($random(seed)) | 8'h80;
			z = 8'($random(seed));
			dl = 8'($random(seed));
			dh = 8'($random(seed)) & 8'h7f;
			if (it == 0) begin
				x = 8'hff;
				y = 8'hff;
				dl = 8'hff;
			end
			if (it == 1)
				y = 8'h00;
			op = it[0] ? 8'h83 : 8'h93;
			base = it[0] ? 16'h000c : {dh, dl};
			prog = '{8'h90, dh, dl, 8'he0, 8'hf5, 8'hf0, 8'h75, 8'hf0, y, 8'ha4, 8'hf0, op,
				8'ha2, 8'he7, 8'h92, 8'hf0, 8'h85, 8'hf0, 8'h82, 8'h75, 8'h00, r, 8'he2,
				8'h88, 8'h83, 8'ha6, 8'he0, 8'h86, 8'hf0, 8'h00};
			for (n = 0; n < 30; n++)
				rom[n] = prog[n];
			dmme_ext_ram_inst.mem[{dh, dl}] = x;
			dmme_ext_ram_inst.mem[{8'hff, r}] = z;
			rst = 1'b1;
			ce = 1'b1;
			repeat (2) @(negedge clk);
			chk8("acc_rst", ACC_RESET, acc);
			chk8("hi_rst", P2_RESET, hi_a);
			rst = 1'b0;
			n = 0;
			for (k = 0; k < 200 && n < 15; k++) begin
				@(negedge clk);
				if (retire === 1'b1)
					n++;
			end
			// Freeze before the trailing filler decodes
			ce = 1'b0;
			chk8("retired", 8'd15, 8'(n));
			chk8("acc", 8'(expect_state(x, y, r, z, base) >> 32), acc);
			chk8("b", 8'(expect_state(x, y, r, z, base) >> 24), b);
			chk16("data_pointer", 16'(expect_state(x, y, r, z, base) >> 8), data_pointer);
			chk8("flags", 8'(expect_state(x, y, r, z, base)), psw & 8'h84);
			chk8("xram", x * y, dmme_ext_ram_inst.mem[{dh, dl}]);
			chk8("hi_idle", P2_RESET, hi_a);
			// One enabled cycle lets the filler byte decode
			ce = 1'b1;
			@(negedge clk);
			chk8("unsup", 8'h01, {7'h00, unsup});
		end
		finish_test;
	end
	initial begin
		#(24 * 300 * 20);
		err_count++;
		finish_test;
	end
endmodule
